// ---- src/aspc_device.sv ----
`timescale 1ns/1ps
`include "aspc_regs.svh"

// How it works
// - Host writes zero in slot byte top bits
// - Slot byte bits five..zero are slot number
// - Select low frames exactly one transaction
// - Data sampled on rising serial clock edge
// - Host shifts each byte LSB first
// - Writes are two or four bytes
// - Host ends writes on byte boundaries
// - Serial outputs tristate during register update
// - Frame sync lasts at most one bit period
// - Output released after the slot's LSB
// - Address mismatch ignores the rest of frame
// - Byte one bit six picks side X
// - Next bytes load control then slot registers
// - Slots counted from frame sync, 8 or 4
module aspc_device (
    aspc_if.device link,
    input wire logic presetn,
    input wire aspc_pkg::aspc_addr_t device_address_straps,
    input wire logic bit_clock_side_x,
    input wire logic frame_sync_side_x,
    input wire aspc_pkg::aspc_byte_t tx_data_side_x,
    input wire logic bit_clock_side_y,
    input wire logic frame_sync_side_y,
    input wire aspc_pkg::aspc_byte_t tx_data_side_y,
    output logic serial_out_side_x,
    output logic serial_out_side_x_oe,
    output logic serial_out_side_y,
    output logic serial_out_side_y_oe,
    output aspc_pkg::aspc_byte_t control_side_x,
    output aspc_pkg::aspc_byte_t control_side_y,
    output aspc_pkg::aspc_slot_t input_slot_side_x,
    output aspc_pkg::aspc_slot_t input_slot_side_y,
    output aspc_pkg::aspc_slot_t output_timeslot_select_x,
    output aspc_pkg::aspc_slot_t output_timeslot_select_y,
    output logic update_busy
);
    import aspc_pkg::*;

    // ****************************************************************
    // Frame state, all on the link clock
    // ****************************************************************
    logic [`ASPC_BIT_CNT_W-1:0] bit_cnt; // Bits taken in this frame
    aspc_byte_t shifter; // Byte being assembled, LSB first

    logic addr_hit; // First byte matched our straps
    logic side_x; // Side chosen by the first byte

    aspc_slot_t in_slot_hold; // Third byte, held until the fourth lands

    aspc_addr_t strap_meta; // First stage, read only by strap_sync
    aspc_addr_t strap_sync; // Straps settled on the link clock

    // ****************************************************************
    // Decode of the incoming bit stream
    // ****************************************************************
    wire frame_rst_n; // Low outside a frame or in reset
    wire frame_full; // Four bytes already taken
    wire byte_done; // This edge completes a byte
    wire [1:0] byte_idx; // Which byte of the frame completes

    aspc_byte_t next_byte; // Byte as it stands after this edge
    wire first_hit; // Address byte matches the straps

    wire commit_ctrl;
    wire commit_slots;

    // Select high ends the frame; any partial byte is dropped with it
    assign frame_rst_n = presetn & ~link.port_sel_n;

    assign frame_full = (bit_cnt == `ASPC_FRAME_FULL);
    assign byte_done = (bit_cnt[2:0] == `ASPC_BYTE_LAST) & ~frame_full;
    assign byte_idx = bit_cnt[4:3];

    // New bit enters at the top, so the first bit ends up as bit zero
    assign next_byte = {link.serial_config_in, shifter[7:1]};
    assign first_hit = (next_byte[`ASPC_ADDR_W-1:0] == strap_sync);

    // Nothing commits unless the address byte matched
    assign commit_ctrl = byte_done & addr_hit & (byte_idx == `ASPC_IDX_CTRL);
    assign commit_slots = byte_done & addr_hit & (byte_idx == `ASPC_IDX_OUT_SLOT);

    // ****************************************************************
    // Strap synchroniser
    // ****************************************************************
    // Straps are static pins; two flops keep metastability off the compare
    always_ff @(posedge link.serial_clk or negedge presetn) begin
        if (!presetn) begin
            strap_meta <= '0;
            strap_sync <= '0;
        end else begin
            strap_meta <= device_address_straps;
            strap_sync <= strap_meta;
        end
    end

    // ****************************************************************
    // Bit capture and frame sequencing
    // ****************************************************************
    // Rising edge capture; the counter freezes after four bytes
    always_ff @(posedge link.serial_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            bit_cnt <= '0;
            shifter <= '0;
            addr_hit <= 1'b0;
            side_x <= 1'b0;
            in_slot_hold <= '0;
            update_busy <= 1'b0;
        end else if (!frame_full) begin
            bit_cnt <= bit_cnt + 1'b1;
            shifter <= next_byte;

            if (byte_done) begin
                case (byte_idx)
                    2'h0: begin
                        // Address byte: match and side choice
                        addr_hit <= first_hit;
                        side_x <= next_byte[`ASPC_SIDE_BIT];
                        update_busy <= first_hit;
                    end

                    `ASPC_IDX_IN_SLOT: begin
                        // Held back so a two-byte-plus frame cannot half-load
                        in_slot_hold <= next_byte[`ASPC_SLOT_NUM_W-1:0];
                    end

                    default: begin
                        // Control and last byte commit below
                        in_slot_hold <= in_slot_hold;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Committed configuration, survives the end of a frame
    // ****************************************************************
    // Both frame lengths work: control lands on byte two, slots on four
    always_ff @(posedge link.serial_clk or negedge presetn) begin
        if (!presetn) begin
            control_side_x <= '0;
            control_side_y <= '0;
            input_slot_side_x <= '0;
            input_slot_side_y <= '0;
            output_timeslot_select_x <= '0;
            output_timeslot_select_y <= '0;
        end else begin
            if (commit_ctrl && side_x) begin
                control_side_x <= next_byte;
            end

            if (commit_ctrl && !side_x) begin
                control_side_y <= next_byte;
            end

            // Top two bits of the slot byte are dropped
            if (commit_slots && side_x) begin
                input_slot_side_x <= in_slot_hold;
                output_timeslot_select_x <= next_byte[`ASPC_SLOT_NUM_W-1:0];
            end

            if (commit_slots && !side_x) begin
                input_slot_side_y <= in_slot_hold;
                output_timeslot_select_y <= next_byte[`ASPC_SLOT_NUM_W-1:0];
            end
        end
    end

    // ****************************************************************
    // Channel output engines, one per side on its own bit clock
    // ****************************************************************
    // Config crosses by being copied only while the busy flag reads low
    // there; the flag must reach a side before the control byte lands,
    // so the serial clock should not outrun the slowest bit clock by much
    aspc_slot u_slot_x (
        .bit_clk(bit_clock_side_x),
        .presetn(presetn),
        .frame_sync(frame_sync_side_x),
        .busy_async(update_busy),
        .compress(control_side_x[`ASPC_CTRL_CPEX_BIT]),
        .idle(control_side_x[`ASPC_CTRL_IDLE_BIT]),
        .slot(output_timeslot_select_x),
        .tx_data(tx_data_side_x),
        .ser_out(serial_out_side_x),
        .ser_oe(serial_out_side_x_oe)
    );

    aspc_slot u_slot_y (
        .bit_clk(bit_clock_side_y),
        .presetn(presetn),
        .frame_sync(frame_sync_side_y),
        .busy_async(update_busy),
        .compress(control_side_y[`ASPC_CTRL_CPEX_BIT]),
        .idle(control_side_y[`ASPC_CTRL_IDLE_BIT]),
        .slot(output_timeslot_select_y),
        .tx_data(tx_data_side_y),
        .ser_out(serial_out_side_y),
        .ser_oe(serial_out_side_y_oe)
    );

endmodule

// ---- src/aspc_regs.svh ----
`ifndef ASPC_REGS_SVH
`define ASPC_REGS_SVH

// ****************************************************************
// Serial frame layout
// ****************************************************************
`define ASPC_BYTE_W 8
`define ASPC_ADDR_W 6
`define ASPC_SLOT_NUM_W 6
`define ASPC_SIDE_BIT 6
`define ASPC_BYTE_LAST 3'h7
`define ASPC_BIT_CNT_W 6
`define ASPC_FRAME_FULL 6'h20
`define ASPC_IDX_CTRL 2'h1
`define ASPC_IDX_IN_SLOT 2'h2
`define ASPC_IDX_OUT_SLOT 2'h3
`define ASPC_BITS_TWO 6'h10
`define ASPC_BITS_FOUR 6'h20

// ****************************************************************
// Control byte fields and slot widths
// ****************************************************************
`define ASPC_CTRL_IDLE_BIT 5
`define ASPC_CTRL_CPEX_BIT 0
`define ASPC_SLOT_W_COMPRESS 4'h8
`define ASPC_SLOT_W_EXPAND 4'h4
`define ASPC_SLOT_CNT_W 10

// ****************************************************************
// Host register offsets on the APB side
// ****************************************************************
`define ASPC_OFF_ADDR_CMD 8'h00
`define ASPC_OFF_CTRL 8'h04
`define ASPC_OFF_IN_SLOT 8'h08
`define ASPC_OFF_OUT_SLOT 8'h0c
`define ASPC_OFF_START 8'h10
`define ASPC_OFF_STATUS 8'h14
`define ASPC_START_BIT 0
`define ASPC_LEN4_BIT 1

// ****************************************************************
// Serial port timing
// ****************************************************************
`define ASPC_PCLK_NS 25
`define ASPC_SCLK_HALF_NS 250
`define ASPC_SCLK_HALF_CYC ((`ASPC_SCLK_HALF_NS + `ASPC_PCLK_NS - 1) / `ASPC_PCLK_NS)

`endif

// ---- src/aspc_pkg.sv ----
package aspc_pkg;
    // Shared byte, address and slot shapes
    typedef logic [7:0] aspc_byte_t;
    typedef logic [5:0] aspc_addr_t;
    typedef logic [5:0] aspc_slot_t;
    // Host shifter sequence
    typedef enum {
        HS_IDLE,
        HS_SETUP,
        HS_LOW,
        HS_HIGH,
        HS_HOLD,
        HS_GAP
    } aspc_host_state_t;
endpackage

// ---- src/aspc_if.sv ----
`timescale 1ns/1ps

// ****************************************************************
// Three-wire configuration link
// ****************************************************************
interface aspc_if;
    logic serial_clk; // Link clock, made by the host
    logic port_sel_n; // Frame select, low during a write
    logic serial_config_in; // Data, LSB first
    modport host (
        output serial_clk,
        output port_sel_n,
        output serial_config_in
    );
    modport device (
        input serial_clk,
        input port_sel_n,
        input serial_config_in
    );
endinterface

// ---- src/aspc_slot.sv ----
`timescale 1ns/1ps
`include "aspc_regs.svh"

// ****************************************************************
// One side's timeslot counter and serial output driver
// ****************************************************************
module aspc_slot (
    input wire logic bit_clk,
    input wire logic presetn,
    input wire logic frame_sync,
    input wire logic busy_async,
    input wire logic compress,
    input wire logic idle,
    input wire aspc_pkg::aspc_slot_t slot,
    input wire aspc_pkg::aspc_byte_t tx_data,
    output logic ser_out,
    output logic ser_oe
);
    import aspc_pkg::*;

    logic fs_meta; // First stage, read only by fs_sync
    logic fs_sync;
    logic fs_prev; // Edge detector memory
    logic busy_meta; // First stage, read only by busy_sync
    logic busy_sync;
    logic cfg_cp; // Config held in the bit clock domain
    logic cfg_idle;
    aspc_slot_t cfg_slot;
    logic [`ASPC_SLOT_CNT_W-1:0] cnt; // Bit position after the frame edge
    wire fs_rise;
    wire [`ASPC_SLOT_CNT_W-1:0] pos;
    wire [`ASPC_SLOT_CNT_W-1:0] start;
    wire [`ASPC_SLOT_CNT_W-1:0] offs;
    wire [3:0] slot_w;
    wire in_slot;
    wire [2:0] bit_idx;

    // Frame edge restarts the count at bit zero
    assign fs_rise = fs_sync & ~fs_prev;
    assign pos = fs_rise ? '0 : cnt;
    // Slot size follows the coding direction
    assign slot_w = cfg_cp ? `ASPC_SLOT_W_COMPRESS : `ASPC_SLOT_W_EXPAND;
    assign start = cfg_cp ? {1'b0, cfg_slot, 3'h0} : {2'h0, cfg_slot, 2'h0};
    assign offs = pos - start;
    assign in_slot = (offs < {6'h0, slot_w});
    // MSB first, so the LSB goes out last in the slot
    assign bit_idx = cfg_cp ? (3'h7 - offs[2:0]) : {1'b0, 2'h3 - offs[1:0]};

    // ****************************************************************
    // Synchronisers for pins and the update flag
    // ****************************************************************
    always_ff @(posedge bit_clk or negedge presetn) begin
        if (!presetn) begin
            fs_meta <= 1'b0;
            fs_sync <= 1'b0;
            fs_prev <= 1'b0;
            busy_meta <= 1'b0;
            busy_sync <= 1'b0;
        end else begin
            fs_meta <= frame_sync;
            fs_sync <= fs_meta;
            fs_prev <= fs_sync;
            busy_meta <= busy_async;
            busy_sync <= busy_meta;
        end
    end

    // Config copied only while no update runs, so the bytes are stable
    always_ff @(posedge bit_clk or negedge presetn) begin
        if (!presetn) begin
            cfg_cp <= 1'b0;
            cfg_idle <= 1'b1;
            cfg_slot <= '0;
        end else if (!busy_sync) begin
            cfg_cp <= compress;
            cfg_idle <= idle;
            cfg_slot <= slot;
        end
    end

    // Counter and registered output; released right after the LSB
    always_ff @(posedge bit_clk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
            ser_out <= 1'b0;
            ser_oe <= 1'b0;
        end else begin
            cnt <= pos + 1'b1;
            ser_out <= tx_data[bit_idx];
            ser_oe <= in_slot & ~cfg_idle & ~busy_sync;
        end
    end
endmodule

// ---- src/aspc_host.sv ----
`timescale 1ns/1ps
`include "aspc_regs.svh"

// ****************************************************************
// Host end: APB registers and the three-wire write shifter
// ****************************************************************
module aspc_host #(
    parameter int HALF_CYC = `ASPC_SCLK_HALF_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    aspc_if.host link
);
    import aspc_pkg::*;

    // Address decode shared by reads and writes
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    aspc_byte_t addr_cmd; // First byte to send
    aspc_byte_t ctrl; // Control byte
    aspc_slot_t in_slot; // Input slot number
    aspc_slot_t out_slot; // Output slot number
    logic busy; // A frame is on the wire
    aspc_host_state_t state;
    logic [7:0] timer; // Half-period countdown
    logic [31:0] frame; // Bits left to send, LSB first
    logic [5:0] bits_left;

    wire access = psel & penable & ~pready; // One wait state
    wire wr = access & pwrite;
    wire mapped = hit(paddr, `ASPC_OFF_ADDR_CMD) | hit(paddr, `ASPC_OFF_CTRL) |
        hit(paddr, `ASPC_OFF_IN_SLOT) | hit(paddr, `ASPC_OFF_OUT_SLOT) |
        hit(paddr, `ASPC_OFF_START) | hit(paddr, `ASPC_OFF_STATUS);
    wire go = wr & hit(paddr, `ASPC_OFF_START) & pwdata[`ASPC_START_BIT] & ~busy;
    wire tick = (timer == 8'h0);
    wire [7:0] half = 8'(HALF_CYC - 1);
    // Top two bits of the slot byte always go out as zero
    wire [31:0] load = {2'h0, out_slot, 2'h0, in_slot, ctrl, addr_cmd};
    wire [31:0] rd_val = hit(paddr, `ASPC_OFF_ADDR_CMD) ? {24'h0, addr_cmd} :
        hit(paddr, `ASPC_OFF_CTRL) ? {24'h0, ctrl} :
        hit(paddr, `ASPC_OFF_IN_SLOT) ? {26'h0, in_slot} :
        hit(paddr, `ASPC_OFF_OUT_SLOT) ? {26'h0, out_slot} :
        hit(paddr, `ASPC_OFF_STATUS) ? {31'h0, busy} : 32'h0;

    // ****************************************************************
    // APB slave
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
            addr_cmd <= '0;
            ctrl <= '0;
            in_slot <= '0;
            out_slot <= '0;
        end else begin
            pready <= access;
            pslverr <= access & ~mapped;
            prdata <= (access & ~pwrite) ? rd_val : 32'h0;
            if (wr && hit(paddr, `ASPC_OFF_ADDR_CMD)) begin
                addr_cmd <= pwdata[7:0];
            end
            if (wr && hit(paddr, `ASPC_OFF_CTRL)) begin
                ctrl <= pwdata[7:0];
            end
            if (wr && hit(paddr, `ASPC_OFF_IN_SLOT)) begin
                in_slot <= pwdata[5:0];
            end
            if (wr && hit(paddr, `ASPC_OFF_OUT_SLOT)) begin
                out_slot <= pwdata[5:0];
            end
        end
    end

    // ****************************************************************
    // Shifter: data changes on falling edges, device samples on rising
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= HS_IDLE;
            busy <= 1'b0;
            timer <= '0;
            frame <= '0;
            bits_left <= '0;
            link.serial_clk <= 1'b0;
            link.port_sel_n <= 1'b1;
            link.serial_config_in <= 1'b0;
        end else begin
            timer <= tick ? half : timer - 1'b1;
            case (state)
                HS_IDLE: begin
                    timer <= half;
                    if (go) begin
                        // Frame length is two or four whole bytes
                        bits_left <= pwdata[`ASPC_LEN4_BIT] ? `ASPC_BITS_FOUR :
                            `ASPC_BITS_TWO;
                        frame <= load;
                        busy <= 1'b1;
                        link.port_sel_n <= 1'b0;
                        link.serial_config_in <= load[0];
                        state <= HS_SETUP;
                    end
                end
                HS_SETUP, HS_LOW: begin
                    if (tick) begin
                        link.serial_clk <= 1'b1;
                        state <= HS_HIGH;
                    end
                end
                HS_HIGH: begin
                    if (tick) begin
                        link.serial_clk <= 1'b0;
                        frame <= {1'b0, frame[31:1]};
                        bits_left <= bits_left - 1'b1;
                        link.serial_config_in <= frame[1];
                        state <= (bits_left == 6'h1) ? HS_HOLD : HS_LOW;
                    end
                end
                HS_HOLD: begin
                    if (tick) begin
                        link.port_sel_n <= 1'b1;
                        state <= HS_GAP;
                    end
                end
                HS_GAP: begin
                    if (tick) begin
                        busy <= 1'b0;
                        state <= HS_IDLE;
                    end
                end
                default: begin
                    state <= HS_IDLE;
                end
            endcase
        end
    end
endmodule

// ---- tb/aspc_asserts.sv ----
`timescale 1ns/1ps

// ****************************************************************
// Link checker on the three wires, sampled on the host clock
// ****************************************************************
module aspc_asserts #(
    parameter int HALF_CYC = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic serial_clk,
    input wire logic port_sel_n,
    input wire logic serial_config_in
);
    logic sclk_q; // Serial clock one cycle late
    logic [5:0] bits; // Rising serial edges seen in this frame
    logic [7:0] hcnt; // Cycles with the serial clock high
    wire sclk_rise = serial_clk && !sclk_q; // Edge where the device takes a bit

    // Cleared while deselected, so each frame counts from zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_q <= 1'b0;
            hcnt <= 8'h00;
            bits <= 6'h00;
        end else begin
            sclk_q <= serial_clk;
            hcnt <= serial_clk ? hcnt + 8'h01 : 8'h00;
            bits <= port_sel_n ? 6'h00 : bits + {5'h00, sclk_rise};
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_clk_low2;
        !serial_clk [*2];
    endsequence
    sequence s_sel_high2;
        port_sel_n [*2];
    endsequence

    // ****************************************************************
    // Framing, clocking, data timing and slot byte top bits
    // ****************************************************************
    a_clk_idle_low: assert property (port_sel_n |-> !serial_clk)
        else $error("Serial clock moved while deselected");
    a_sel_setup: assert property ($fell(port_sel_n) |-> s_clk_low2)
        else $error("Serial clock rose too soon after select");
    a_sel_hold: assert property ($fell(serial_clk) |-> !port_sel_n [*2])
        else $error("Select released too soon after clock");
    a_sel_gap: assert property ($rose(port_sel_n) |-> s_sel_high2)
        else $error("Select inactive time too short");
    a_data_hold: assert property (serial_clk && sclk_q |-> $stable(serial_config_in))
        else $error("Data moved while serial clock high");
    a_data_edge: assert property (!port_sel_n && $changed(serial_config_in)
        |-> !serial_clk && ($past(serial_clk) || $fell(port_sel_n)))
        else $error("Data moved away from a falling edge");
    a_high_width: assert property ($fell(serial_clk) |-> hcnt == 8'(HALF_CYC))
        else $error("Serial clock high phase wrong length");
    a_frame_len: assert property ($rose(port_sel_n) |-> bits == 6'h10 || bits == 6'h20)
        else $error("Frame not two or four whole bytes");
    a_slot_top: assert property (sclk_rise && bits >= 6'h1e |-> !serial_config_in)
        else $error("Output slot byte top bits not zero");
endmodule

// ---- tb/adpcm_serial_config_port_tb.sv ----
`timescale 1ns/1ps

// ****************************************************************
// Bench: host end over APB, device end, link checker
// ****************************************************************
module adpcm_serial_config_port_tb;
    import aspc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic bclk, fsync, sox, soxe, soy, soye, busy; // Bit clock side
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic e;
    aspc_addr_t straps; // Strapped device address
    aspc_byte_t tx, cx, cy, ec[2]; // ec: expected control, index 1 is side X
    aspc_slot_t ix, iy, ox, oy, ei[2], eo[2], s;
    logic [39:0] exp_q[$]; // Expected config per frame
    int failures, checked;

    aspc_if link_i ();
    aspc_host #(.HALF_CYC(2)) aspc_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link_i.host));
    aspc_device aspc_device_i (.link(link_i.device), .presetn(presetn),
        .device_address_straps(straps), .bit_clock_side_x(bclk), .frame_sync_side_x(fsync),
        .tx_data_side_x(tx), .bit_clock_side_y(bclk), .frame_sync_side_y(fsync),
        .tx_data_side_y(tx), .serial_out_side_x(sox), .serial_out_side_x_oe(soxe),
        .serial_out_side_y(soy), .serial_out_side_y_oe(soye), .control_side_x(cx),
        .control_side_y(cy), .input_slot_side_x(ix), .input_slot_side_y(iy),
        .output_timeslot_select_x(ox), .output_timeslot_select_y(oy), .update_busy(busy));
    aspc_asserts #(.HALF_CYC(2)) aspc_asserts_i (.pclk(pclk), .presetn(presetn),
        .serial_clk(link_i.serial_clk), .port_sel_n(link_i.port_sel_n),
        .serial_config_in(link_i.serial_config_in));

    // Host clock 25 ns, bit clock 48 ns, unrelated
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        bclk = 1'b0;
        forever #24 bclk = ~bclk;
    end

    task automatic compare_val(input string what, input logic [39:0] exp, input logic [39:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("Counts: %0d checked, %0d failures", checked, failures);
        if (failures == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // One APB transfer; holds the request until pready is seen
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            print_verdict();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Load the host, note the expected config, start, wait for idle
    task automatic frame(input logic sd, input aspc_addr_t a, input aspc_byte_t c,
        input aspc_byte_t i, input aspc_byte_t o, input logic len4);
        int n;
        apb(1'b1, 8'h00, {24'h0, 1'b0, sd, a});
        apb(1'b1, 8'h04, {24'h0, c});
        apb(1'b1, 8'h08, {24'h0, i});
        apb(1'b1, 8'h0c, {24'h0, o});
        if (a == straps) begin
            ec[sd] = c;
            if (len4) begin
                ei[sd] = i[5:0];
                eo[sd] = o[5:0];
            end
        end
        exp_q.push_back({ec[1], ec[0], ei[1], ei[0], eo[1], eo[0]});
        apb(1'b1, 8'h10, {30'h0, len4, 1'b1});
        n = 0;
        do begin
            apb(1'b0, 8'h14, 32'h0);
            n++;
        end while (r[0] !== 1'b0 && n < 100);
        if (n >= 100) begin
            failures++;
            print_verdict();
        end
    endtask

    // Frame sync one bit period wide, then watch side X's slot
    task automatic chan(input logic m);
        int first, nb;
        logic [7:0] got;
        first = 0;
        nb = 0;
        got = 8'h00;
        @(posedge bclk);
        fsync <= 1'b1;
        for (int k = 1; k <= 40; k++) begin
            @(posedge bclk);
            fsync <= 1'b0;
            @(negedge bclk);
            if (soxe === 1'b1) begin
                first = (nb == 0) ? k : first;
                got = {got[6:0], sox};
                nb++;
            end
        end
        compare_val("slot start", 40'(3 + (m ? 8 : 4) * s), 40'(first));
        compare_val("slot width", 40'(m ? 8 : 4), 40'(nb));
        compare_val("slot data", 40'(m ? tx : {4'h0, tx[3:0]}), 40'(got));
    endtask

    // Compare committed config whenever a frame ends
    initial forever begin
        @(posedge link_i.port_sel_n);
        if (exp_q.size()) compare_val("cfg", exp_q.pop_front(), {cx, cy, ix, iy, ox, oy});
    end

    initial begin
        void'($urandom(32'h0b14));
        #1 {presetn, psel, penable, pwrite, paddr, pwdata, fsync, tx} = '0;
        straps = 6'($urandom);
        ec = '{8'h00, 8'h00};
        ei = '{6'h00, 6'h00};
        eo = '{6'h00, 6'h00};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // Unmapped address is refused
        apb(1'b0, 8'h20, 32'h0);
        compare_val("unmapped error", 40'h1, 40'(e));
        compare_val("unmapped data", 40'h0, 40'(r));
        $display("Test unmapped done");
        // Random frames, some to another address
        repeat (12) begin
            frame(1'($urandom), ($urandom % 4 == 0) ? straps ^ 6'h01 : straps, 8'($urandom),
                8'($urandom), 8'($urandom), 1'($urandom));
        end
        $display("Test frames done");
        // Expand then compress slot on side X
        for (int m = 0; m < 2; m++) begin
            tx <= 8'($urandom);
            s = 6'($urandom % 4);
            frame(1'b1, straps, {7'h0, m[0]}, 8'h00, {2'h0, s}, 1'b1);
            repeat (6) @(posedge bclk);
            chan(m[0]);
        end
        $display("Test slots done");
        print_verdict();
    end
endmodule
